// [hdl/handler_map.svh]
`ifndef HANDLER_MAP_SVH
`define HANDLER_MAP_SVH
`define CTRL_OFS 12'h000
`define KEY_OFS 12'h004
`define STATUS_OFS 12'h008
`define CTRL_TRIG_EXT_BIT 0
`define CTRL_SEQ_BIT 1
`define CTRL_ILK_USE_BIT 2
`define CTRL_RESET 3'h0
`define KEY_START_BIT 0
`define KEY_STOP_BIT 1
`define KEY_OPEN_BIT 2
`define KEY_VCHK_BIT 3
`define KEY_CCHK_BIT 4
`define STAT_STATE_LSB 0
`define STAT_PIN_LSB 5
`define STAT_OUT_LSB 14
`define IN_TRIG 0
`define IN_VCHK 1
`define IN_CCHK 2
`define IN_OPEN 3
`define IN_START 4
`define IN_STOP 5
`define IN_ILK 6
`define IN_LOCK 7
`define IN_REAR 8
`define IN_COUNT 9
`define CLK_PERIOD_NS 10
`define TRIG_MIN_NS 100000
`define TRIG_MIN_CYCLES ((`TRIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [hdl/handler_pkg.sv]
`include "handler_map.svh"
package handler_pkg;
    typedef logic [`IN_COUNT-1:0] pins_t;
    typedef enum logic [4:0] {
        ST_STOP = 5'h01,
        ST_ARM = 5'h02,
        ST_MEAS = 5'h04,
        ST_CHECK = 5'h08,
        ST_OPEN = 5'h10
    } state_t;
endpackage : handler_pkg

// [hdl/pin_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if;
    handler_pkg::pins_t level;
    handler_pkg::pins_t fall;
    modport src (output level, output fall);
    modport dst (input level, input fall);
endinterface : pin_sync_if
`default_nettype wire

// [hdl/pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "handler_map.svh"
module pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw active-low pins
    input wire handler_pkg::pins_t pinsN,
    // clean levels and falling-edge pulses
    pin_sync_if.src so
);
    import handler_pkg::*;
    genvar i;
    generate
        for (i = 0; i < `IN_COUNT; i = i + 1) begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            logic fl;
            // s1 feeds s2 only; a change counts once s2 and s3 agree
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                end else begin
                    s1 <= pinsN[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    lvl <= 1'b1;
                    fl <= 1'b0;
                end else begin
                    fl <= 1'b0;
                    if (s2 == s3 && lvl != s3) begin
                        lvl <= s3;
                        fl <= ~s3;
                    end
                end
            end
            assign so.level[i] = lvl;
            assign so.fall[i] = fl;
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// [hdl/handler_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "handler_map.svh"
module handler_top #(
    parameter int unsigned TRIG_HOLD_CYCLES = `TRIG_MIN_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // handler inputs, active low
    input wire logic trig_n,
    input wire logic vcheck_n,
    input wire logic ccheck_n,
    input wire logic open_n,
    input wire logic start_n,
    input wire logic stop_n,
    input wire logic interlock_n,
    input wire logic panel_lock_n,
    input wire logic rear_trig_in,
    // handler outputs, active low
    output logic vcheck_go_n,
    output logic ccheck_go_n,
    output logic open_go_n,
    output logic comp_go_n,
    output logic meas_done_n,
    output logic index_n,
    output logic start_permitted_n,
    output logic hv_on_n,
    output logic fault_n,
    // measuring core
    input wire logic coreMeasDone,
    input wire logic coreCompPass,
    input wire logic coreVchkDone,
    input wire logic coreVchkPass,
    input wire logic coreCchkDone,
    input wire logic coreCchkPass,
    input wire logic coreOpenDone,
    input wire logic coreOpenPass,
    input wire logic coreFault,
    output logic hvEnable,
    output logic measStart,
    output logic seqStart,
    output logic vchkStart,
    output logic cchkStart,
    output logic openStart,
    output logic measAbort
);
    import handler_pkg::*;

    pin_sync_if ps ();
    pins_t rawPins;
    assign rawPins[`IN_TRIG] = trig_n;
    assign rawPins[`IN_VCHK] = vcheck_n;
    assign rawPins[`IN_CCHK] = ccheck_n;
    assign rawPins[`IN_OPEN] = open_n;
    assign rawPins[`IN_START] = start_n;
    assign rawPins[`IN_STOP] = stop_n;
    assign rawPins[`IN_ILK] = interlock_n;
    assign rawPins[`IN_LOCK] = panel_lock_n;
    assign rawPins[`IN_REAR] = rear_trig_in;

    pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pinsN(rawPins),
        .so(ps.src)
    );

    state_t state_reg;
    state_t state_next;
    logic [2:0] ctrl_reg;
    logic [4:0] keys_reg;
    logic checkIsC_reg;
    logic handlerStart_reg;
    logic [15:0] trigHold_reg;

    logic trigExt;
    logic seqOn;
    logic ilkUse;
    logic ilkHigh;
    logic locked;
    logic stopReq;
    logic startH;
    logic startP;
    logic startAcc;
    logic openAcc;
    logic vchkAcc;
    logic cchkAcc;
    logic trigAcc;
    logic hvCut;
    logic enterMeas;
    logic enterSeq;
    logic enterVchk;
    logic enterCchk;
    logic enterOpen;
    logic endMeas;
    logic endCheck;
    logic endOpen;
    logic hvNext;
    logic apbAccess;

    assign trigExt = ctrl_reg[`CTRL_TRIG_EXT_BIT];
    assign seqOn = ctrl_reg[`CTRL_SEQ_BIT];
    assign ilkUse = ctrl_reg[`CTRL_ILK_USE_BIT];
    // pins are low-true, so a high level means deasserted
    assign ilkHigh = ps.level[`IN_ILK];
    assign locked = ~ps.level[`IN_LOCK];

    // stop bypasses lock, remote and every other condition
    assign stopReq = ps.fall[`IN_STOP] | keys_reg[`KEY_STOP_BIT];
    // handler start: interlock gating regardless of the setting
    assign startH = ps.fall[`IN_START] & ~ilkHigh;
    // panel start: lock always gates, interlock only when in use
    assign startP = keys_reg[`KEY_START_BIT] & ~locked & ~(ilkHigh & ilkUse);
    assign startAcc = (startH | startP) & (state_reg == ST_STOP);
    assign openAcc = (state_reg == ST_STOP)
        & ((ps.fall[`IN_OPEN] & ~ilkHigh)
        | (keys_reg[`KEY_OPEN_BIT] & ~locked));
    assign vchkAcc = (state_reg == ST_ARM) & ~seqOn
        & (ps.fall[`IN_VCHK] | (keys_reg[`KEY_VCHK_BIT] & ~locked));
    assign cchkAcc = (state_reg == ST_ARM) & ~seqOn & ~vchkAcc
        & (ps.fall[`IN_CCHK] | (keys_reg[`KEY_CCHK_BIT] & ~locked));
    // both trigger pins share one path; ignored outside external mode
    assign trigAcc = trigExt & (trigHold_reg == 16'h0000)
        & (ps.fall[`IN_TRIG] | ps.fall[`IN_REAR]);
    // a lid opened under voltage drops it when gating applies
    assign hvCut = ilkHigh & (ilkUse | handlerStart_reg);

    always_comb begin
        state_next = state_reg;
        enterMeas = 1'b0;
        enterSeq = 1'b0;
        enterVchk = 1'b0;
        enterCchk = 1'b0;
        enterOpen = 1'b0;
        endMeas = 1'b0;
        endCheck = 1'b0;
        endOpen = 1'b0;
        if (stopReq || coreFault) begin
            state_next = ST_STOP;
        end else begin
            case (state_reg)
                ST_STOP: begin
                    if (startAcc) begin
                        if (seqOn) begin
                            state_next = ST_MEAS;
                            enterSeq = 1'b1;
                        end else if (!trigExt) begin
                            state_next = ST_MEAS;
                            enterMeas = 1'b1;
                        end else begin
                            state_next = ST_ARM;
                        end
                    end else if (openAcc) begin
                        state_next = ST_OPEN;
                        enterOpen = 1'b1;
                    end
                end
                ST_ARM: begin
                    if (hvCut) begin
                        state_next = ST_STOP;
                    end else if (vchkAcc) begin
                        state_next = ST_CHECK;
                        enterVchk = 1'b1;
                    end else if (cchkAcc) begin
                        state_next = ST_CHECK;
                        enterCchk = 1'b1;
                    end else if (trigAcc || !trigExt) begin
                        state_next = ST_MEAS;
                        enterMeas = 1'b1;
                    end
                end
                ST_MEAS: begin
                    if (hvCut) begin
                        state_next = ST_STOP;
                    end else if (coreMeasDone) begin
                        endMeas = 1'b1;
                        state_next = seqOn ? ST_STOP : ST_ARM;
                    end
                end
                ST_CHECK: begin
                    if (hvCut) begin
                        state_next = ST_STOP;
                    end else if (checkIsC_reg ? coreCchkDone : coreVchkDone) begin
                        endCheck = 1'b1;
                        state_next = ST_ARM;
                    end
                end
                ST_OPEN: begin
                    if (coreOpenDone) begin
                        endOpen = 1'b1;
                        state_next = ST_STOP;
                    end
                end
                default: begin
                    state_next = ST_STOP;
                end
            endcase
        end
    end
    assign hvNext = (state_next == ST_ARM) | (state_next == ST_MEAS)
        | (state_next == ST_CHECK);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_STOP;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            checkIsC_reg <= 1'b0;
            handlerStart_reg <= 1'b0;
        end else begin
            if (enterVchk || enterCchk) begin
                checkIsC_reg <= enterCchk;
            end
            if (startAcc) begin
                handlerStart_reg <= startH;
            end
        end
    end

    // guards against contact bounce re-triggering inside one pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            trigHold_reg <= 16'h0000;
        end else if (trigAcc) begin
            trigHold_reg <= 16'(TRIG_HOLD_CYCLES);
        end else if (trigHold_reg != 16'h0000) begin
            trigHold_reg <= trigHold_reg - 16'h0001;
        end
    end

    // core commands: voltage enable level plus start and abort strobes
    always_ff @(posedge clk) begin
        if (rst) begin
            hvEnable <= 1'b0;
            measStart <= 1'b0;
            seqStart <= 1'b0;
            vchkStart <= 1'b0;
            cchkStart <= 1'b0;
            openStart <= 1'b0;
            measAbort <= 1'b0;
        end else begin
            hvEnable <= hvNext;
            measStart <= enterMeas;
            seqStart <= enterSeq;
            vchkStart <= enterVchk;
            cchkStart <= enterCchk;
            openStart <= enterOpen;
            measAbort <= (state_reg != ST_STOP) & (state_next == ST_STOP)
                & ~endMeas & ~endOpen;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hv_on_n <= 1'b1;
            start_permitted_n <= 1'b1;
            fault_n <= 1'b1;
        end else begin
            hv_on_n <= ~hvNext;
            start_permitted_n <= ilkHigh;
            fault_n <= ~coreFault;
        end
    end

    // done and index rise at each new operation so every low is a fresh edge
    always_ff @(posedge clk) begin
        if (rst) begin
            meas_done_n <= 1'b1;
            index_n <= 1'b1;
        end else if (enterMeas || enterSeq || enterVchk || enterCchk || enterOpen) begin
            meas_done_n <= 1'b1;
            index_n <= 1'b1;
        end else if (endMeas || endCheck || endOpen) begin
            meas_done_n <= 1'b0;
            index_n <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            comp_go_n <= 1'b1;
        end else if (enterMeas || enterSeq) begin
            comp_go_n <= 1'b1;
        end else if (endMeas) begin
            comp_go_n <= ~coreCompPass;
        end
    end

    // in sequence mode the core reports check verdicts mid-run
    always_ff @(posedge clk) begin
        if (rst) begin
            vcheck_go_n <= 1'b1;
            ccheck_go_n <= 1'b1;
        end else begin
            if (enterVchk || enterSeq) begin
                vcheck_go_n <= 1'b1;
            end else if (coreVchkDone && ((state_reg == ST_CHECK && !checkIsC_reg)
                    || (state_reg == ST_MEAS && seqOn))) begin
                vcheck_go_n <= ~coreVchkPass;
            end
            if (enterCchk || enterSeq) begin
                ccheck_go_n <= 1'b1;
            end else if (coreCchkDone && ((state_reg == ST_CHECK && checkIsC_reg)
                    || (state_reg == ST_MEAS && seqOn))) begin
                ccheck_go_n <= ~coreCchkPass;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            open_go_n <= 1'b1;
        end else if (enterOpen) begin
            open_go_n <= 1'b1;
        end else if (endOpen) begin
            open_go_n <= ~coreOpenPass;
        end
    end

    // apb: one wait state, so pready and read data both come from flops
    assign apbAccess = psel & penable & pready;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && penable && !pready) begin
                case (paddr)
                    `CTRL_OFS: begin
                        prdata <= {29'h00000000, ctrl_reg};
                    end
                    `KEY_OFS: begin
                        prdata <= 32'h00000000;
                    end
                    `STATUS_OFS: begin
                        prdata[`STAT_STATE_LSB +: 5] <= state_reg;
                        prdata[`STAT_PIN_LSB +: `IN_COUNT] <= ps.level;
                        prdata[`STAT_OUT_LSB +: 9] <= {fault_n, hv_on_n,
                            start_permitted_n, index_n, meas_done_n,
                            comp_go_n, open_go_n, ccheck_go_n, vcheck_go_n};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (apbAccess && pwrite && paddr == `CTRL_OFS) begin
            ctrl_reg <= pwdata[2:0];
        end
    end

    // panel keys are one-cycle pulses; a locked panel still passes stop
    always_ff @(posedge clk) begin
        if (rst) begin
            keys_reg <= 5'h00;
        end else if (apbAccess && pwrite && paddr == `KEY_OFS) begin
            keys_reg <= pwdata[4:0];
        end else begin
            keys_reg <= 5'h00;
        end
    end
endmodule : handler_top
`default_nettype wire

// [sim/core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // strobes from the block: meas/seq, vchk, cchk, open
    input wire logic [3:0] go,
    input wire logic abort,
    // answer delay, at least 2
    input wire logic [7:0] dly,
    // one-cycle done pulses
    output logic [3:0] done
);
    logic [7:0] cntReg [4];

    // an abort drops every pending answer, as the real core would
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (rst || abort) begin
                cntReg[i] <= 8'h00;
                done[i] <= 1'b0;
            end else begin
                done[i] <= (cntReg[i] == 8'h01);
                if (go[i]) begin
                    cntReg[i] <= dly;
                end else if (cntReg[i] != 8'h00) begin
                    cntReg[i] <= cntReg[i] - 8'h01;
                end
            end
        end
    end
endmodule : core_model
`default_nettype wire

// [sim/handler_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module handler_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic start_n,
    input wire logic stop_n,
    input wire logic interlock_n,
    input wire logic comp_go_n,
    input wire logic meas_done_n,
    input wire logic start_permitted_n,
    input wire logic hv_on_n,
    input wire logic fault_n,
    input wire logic coreMeasDone,
    input wire logic coreCompPass,
    input wire logic coreFault,
    input wire logic hvEnable,
    input wire logic measAbort
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    hv_mirror_a: assert property (hvEnable == !hv_on_n)
        else $error("voltage-on output disagrees with voltage enable");
    fault_follow_a: assert property (!$past(rst) |-> fault_n == !$past(coreFault))
        else $error("fault output does not follow core fault");
    done_verdict_a: assert property ((coreMeasDone && hvEnable && !coreFault && stop_n)
        |=> !meas_done_n && comp_go_n == !$past(coreCompPass))
        else $error("done or verdict wrong after measurement");
    permit_level_a: assert property (interlock_n [*6] |-> start_permitted_n == interlock_n)
        else $error("start-permitted does not follow interlock");
    start_gated_a: assert property ((interlock_n && !hvEnable) [*6] ##1
        ($fell(start_n) && interlock_n) |=> !hvEnable [*6])
        else $error("voltage came on with interlock high");
    stop_kills_a: assert property ($fell(stop_n) |-> ##[1:6] !hvEnable)
        else $error("stop did not remove voltage");
    stop_abort_a: assert property ($fell(stop_n) && hvEnable |-> ##[1:6] measAbort)
        else $error("stop did not abort measurement");
    fault_off_a: assert property (coreFault |-> ##[1:3] !hvEnable)
        else $error("fault did not remove voltage");
    apb_wait_a: assert property (psel && $rose(penable) |=> pready)
        else $error("bus answer not one wait state");
    err_qualified_a: assert property (pslverr |-> pready)
        else $error("bus error without ready");
endmodule : handler_monitor
bind handler_top handler_monitor mon (.clk, .rst, .psel, .penable, .pready, .pslverr,
    .start_n, .stop_n, .interlock_n, .comp_go_n, .meas_done_n, .start_permitted_n,
    .hv_on_n, .fault_n, .coreMeasDone, .coreCompPass, .coreFault, .hvEnable, .measAbort);
`default_nettype wire

// [sim/handler_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module handler_top_tb;
    import handler_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, coreFault;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    logic [8:0] pinN, outN;
    logic [3:0] pass, done;
    logic [7:0] dly;
    logic hvEnable, measStart, seqStart, vchkStart, cchkStart, openStart, measAbort;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    handler_top #(.TRIG_HOLD_CYCLES(8)) dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .trig_n(pinN[0]), .vcheck_n(pinN[1]),
        .ccheck_n(pinN[2]), .open_n(pinN[3]), .start_n(pinN[4]), .stop_n(pinN[5]),
        .interlock_n(pinN[6]), .panel_lock_n(pinN[7]), .rear_trig_in(pinN[8]),
        .vcheck_go_n(outN[0]), .ccheck_go_n(outN[1]), .open_go_n(outN[2]),
        .comp_go_n(outN[3]), .meas_done_n(outN[4]), .index_n(outN[5]),
        .start_permitted_n(outN[6]), .hv_on_n(outN[7]), .fault_n(outN[8]),
        .coreMeasDone(done[0]), .coreCompPass(pass[0]), .coreVchkDone(done[1]),
        .coreVchkPass(pass[1]), .coreCchkDone(done[2]), .coreCchkPass(pass[2]),
        .coreOpenDone(done[3]), .coreOpenPass(pass[3]), .coreFault, .hvEnable, .measStart,
        .seqStart, .vchkStart, .cchkStart, .openStart, .measAbort);
    core_model core (.clk, .rst, .go({openStart, cchkStart, vchkStart, measStart | seqStart}),
        .abort(measAbort), .dly, .done);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic go_level(logic p);
        return ~p;
    endfunction : go_level

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %0h", $time, m, got);
        end
    endtask : chk

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // low pulse longer than the trigger hold-off of 8 cycles
    task automatic pulse(int i);
        @(posedge clk);
        pinN[i] <= 1'b0;
        repeat (10) @(posedge clk);
        pinN[i] <= 1'b1;
    endtask : pulse

    task automatic await(int i, logic v);
        for (int n = 0; n < 400 && outN[i] !== v; n++) @(posedge clk);
        chk(outN[i], v, "output level");
    endtask : await

    // pass then fail verdict; look only once the operation has ended
    task automatic op(int pin, int out);
        for (int p = 1; p >= 0; p--) begin
            pass[pin] <= p[0];
            pulse(pin);
            await(4, 1'b1);
            await(4, 1'b0);
            chk(outN[out], go_level(p[0]), "check verdict");
        end
    endtask : op

    initial begin
        void'($urandom(32'h905D));
        {rst, psel, penable, pwrite, coreFault} = 5'h10;
        {paddr, pwdata, pass, dly, pinN} = '1;
        dly = 8'h04;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(outN, 9'h1FF, "idle outputs");
        apb(1'b0, 12'h00C, 32'h0);
        chk(err, 1'b1, "unmapped error flag");
        chk(rd, 32'h0, "unmapped read data");
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[4:0], ST_STOP, "state after reset");
        pinN[6] <= 1'b0;
        op(3, 2);
        pulse(4);
        await(7, 1'b0);
        for (int i = 0; i < 6; i++) begin
            pass[0] <= 1'($urandom);
            dly <= 8'(2 + $urandom % 20);
            await(4, 1'b1);
            await(4, 1'b0);
            chk(outN[5], 1'b0, "index");
            chk(outN[3], go_level(pass[0]), "comparison verdict");
        end
        dly <= 8'd200;
        await(4, 1'b1);
        pulse(5);
        await(7, 1'b1);
        pinN[6] <= 1'b1;
        repeat (8) @(posedge clk);
        chk(outN[6], 1'b1, "start blocked");
        pulse(4);
        repeat (10) @(posedge clk);
        chk(outN[7], 1'b1, "voltage blocked");
        pinN[6] <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        pulse(4);
        await(7, 1'b0);
        op(1, 0);
        op(2, 1);
        dly <= 8'd40;
        for (int k = 0; k < 2; k++) begin
            pass[0] <= 1'($urandom);
            pulse(k == 0 ? 8 : 0);
            await(4, 1'b1);
            await(4, 1'b0);
            chk(outN[3], go_level(pass[0]), "triggered verdict");
        end
        apb(1'b1, 12'h004, 32'h2);
        await(7, 1'b1);
        apb(1'b1, 12'h000, 32'h5);
        pulse(4);
        await(7, 1'b0);
        pinN[6] <= 1'b1;
        await(7, 1'b1);
        apb(1'b1, 12'h000, 32'h1);
        pinN[7] <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h004, 32'h1);
        repeat (10) @(posedge clk);
        chk(outN[7], 1'b1, "locked panel start");
        pinN[7] <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h004, 32'h1);
        await(7, 1'b0);
        pinN[7] <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h004, 32'h2);
        await(7, 1'b1);
        pinN[7] <= 1'b1;
        pinN[6] <= 1'b0;
        apb(1'b1, 12'h000, 32'h2);
        dly <= 8'd6;
        pulse(4);
        await(4, 1'b0);
        await(7, 1'b1);
        apb(1'b1, 12'h000, 32'h0);
        pulse(4);
        await(7, 1'b0);
        coreFault <= 1'b1;
        await(8, 1'b0);
        await(7, 1'b1);
        coreFault <= 1'b0;
        await(8, 1'b1);
        tally_and_finish();
    end
endmodule : handler_top_tb
`default_nettype wire
